// ---- hw/fp_status_defines.vh ----
// Constants of the floating-point control word and operand encodings
`ifndef FP_STATUS_DEFINES_VH
`define FP_STATUS_DEFINES_VH
// Control word field positions
`define RND_LO 0
`define RND_HI 1
`define FLAG_LO 2
`define FLAG_HI 6
`define ENA_LO 7
`define ENA_HI 11
`define CAUSE_LO 12
`define CAUSE_HI 17
`define CAUSE_UNIMP 17
`define FS_BIT 24
`define CC0_BIT 23
`define CC_HI_LO 25
`define CC_HI_HI 31
// Bit index inside the five-bit exception groups
`define EXC_INEXACT 0
`define EXC_UNDERFLOW 1
`define EXC_OVERFLOW 2
`define EXC_DIVZERO 3
`define EXC_INVALID 4
// Rounding selections
`define ROUND_NEAREST_EVEN 2'h0
`define ROUND_TOWARD_ZERO 2'h1
`define ROUND_TOWARD_PLUS_INF 2'h2
`define ROUND_TOWARD_MINUS_INF 2'h3
// Control word reset value
`define CTRL_RESET 32'h00000000
// Single format layout
`define SGL_EXP_W 8
`define SGL_FRAC_W 23
`define SGL_BIAS 127
`define SGL_EMAX 127
`define SGL_EMIN (-126)
// Double format layout
`define DBL_EXP_W 11
`define DBL_FRAC_W 52
`define DBL_BIAS 1023
`define DBL_EMAX 1023
`define DBL_EMIN (-1022)
// Operand class codes
`define CLS_ZERO 3'h0
`define CLS_DENORM 3'h1
`define CLS_NORMAL 3'h2
`define CLS_INF 3'h3
`define CLS_SNAN 3'h4
`define CLS_QNAN 3'h5
`endif

// ---- hw/fp_operand_classify.v ----
// Operand class decoder for single, double and fixed-point values
`timescale 1ns/1ps
`default_nettype none
`include "fp_status_defines.vh"
module fp_operand_classify (
    // Operand
    input wire [63:0] OPERAND,
    input wire IS_DOUBLE,
    input wire IS_FIXED,
    input wire FIXED_LONG,
    // Results
    output wire [2:0] CLASS_CODE,
    output wire SIGN,
    output wire signed [12:0] UNBIASED_EXP
);
    // Single fields
    wire [`SGL_EXP_W-1:0] s_exp = OPERAND[30:23];
    wire [`SGL_FRAC_W-1:0] s_frac = OPERAND[`SGL_FRAC_W-1:0];
    // Double fields
    wire [`DBL_EXP_W-1:0] d_exp = OPERAND[62:52];
    wire [`DBL_FRAC_W-1:0] d_frac = OPERAND[`DBL_FRAC_W-1:0];
    // Selected fields
    wire exp_all_one = IS_DOUBLE ? (&d_exp) : (&s_exp);
    wire exp_all_zero = IS_DOUBLE ? ~(|d_exp) : ~(|s_exp);
    wire frac_nz = IS_DOUBLE ? (|d_frac) : (|s_frac);
    wire frac_msb = IS_DOUBLE ? d_frac[`DBL_FRAC_W-1] : s_frac[`SGL_FRAC_W-1];
    // Fixed-point: signed two's complement only
    wire fix_sign = FIXED_LONG ? OPERAND[63] : OPERAND[31];
    wire fix_zero = FIXED_LONG ? ~(|OPERAND) : ~(|OPERAND[31:0]);
    // Class selection
    reg [2:0] cls;
    always @* begin
        if (IS_FIXED) begin
            cls = fix_zero ? `CLS_ZERO : `CLS_NORMAL;
        end else if (exp_all_one) begin
            cls = frac_nz ? (frac_msb ? `CLS_SNAN : `CLS_QNAN) : `CLS_INF;
        end else if (exp_all_zero) begin
            cls = frac_nz ? `CLS_DENORM : `CLS_ZERO;
        end else begin
            cls = `CLS_NORMAL;
        end
    end
    assign CLASS_CODE = cls;
    assign SIGN = IS_FIXED ? fix_sign : (IS_DOUBLE ? OPERAND[63] : OPERAND[31]);
    assign UNBIASED_EXP = IS_DOUBLE ?
        ($signed({2'h0, d_exp}) - 13'sd`DBL_BIAS) :
        ($signed({5'h00, s_exp}) - 13'sd`SGL_BIAS);
endmodule // fp_operand_classify
`default_nettype wire

// ---- hw/fp_status_exception_logic.v ----
// Exception status and rounding control of the floating-point unit
//
// Notes on behaviour
// - Six cause bits show last operation.
// - Several exceptions set several cause bits.
// - Arithmetic rewrites cause; control writes load it when no op completes.
// - Unimplemented bit only when emulation needed.
// - Trap suppresses result; only cause changes.
// - Cause and enable both set traps.
// - Unimplemented cause always traps.
// - Untrapped ops store default result.
// - Flags sticky, set on untrapped exceptions.
// - Only control writes clear flags.
// - Trapped ops leave flags alone.
// - Two-bit rounding field, four modes.
// - Nearest mode ties go to even.
// - Single format eight-bit exponent, bias 127.
// - Double format eleven-bit exponent, bias 1023.
// - Exponent extremes mean NaN/inf/denormal/zero.
// - NaN with fraction MSB set signals.
// - Fixed point is signed two's complement.
// - Control read waits for pipeline drain.
`timescale 1ns/1ps
`default_nettype none
`include "fp_status_defines.vh"
module fp_status_exception_logic #(
    parameter PIPE_DEPTH_W = 4
) (
    // Clock and reset
    input wire CLK,
    input wire NRST,
    // Operation completion from the arithmetic datapath
    input wire OP_DONE,
    input wire [5:0] OP_CAUSE,
    input wire OP_COMPARE,
    input wire [7:0] OP_COND,
    // Pipeline occupancy
    input wire [PIPE_DEPTH_W-1:0] OPS_IN_FLIGHT,
    // Control word moves from the integer pipeline
    input wire CTRL_WRITE,
    input wire [31:0] CTRL_WDATA,
    input wire CTRL_READ_REQ,
    output wire CTRL_READ_ACK,
    output wire [31:0] CTRL_RDATA,
    // Result handling
    input wire [63:0] DEFAULT_RESULT,
    output wire RESULT_WRITE,
    output wire [63:0] RESULT_DATA,
    output wire FP_EXCEPTION,
    // Rounding and format control
    output wire [1:0] ROUNDING_SELECT,
    output wire FLUSH_DENORM,
    // Operand classify port
    input wire [63:0] CLASS_OPERAND,
    input wire CLASS_IS_DOUBLE,
    input wire CLASS_IS_FIXED,
    input wire CLASS_FIXED_LONG,
    output wire [2:0] CLASS_CODE,
    output wire CLASS_SIGN,
    output wire signed [12:0] CLASS_EXP,
    // Rounding increment helper for the selected mode
    input wire ROUND_SIGN,
    input wire ROUND_LSB,
    input wire ROUND_GUARD,
    input wire ROUND_STICKY,
    output wire ROUND_INCREMENT
);
    // Control word fields
    reg [1:0] rounding_select_ff;
    reg [4:0] flag_ff;
    reg [4:0] enable_ff;
    reg [5:0] cause_ff;
    reg cc0_ff;
    reg [6:0] cc_hi_ff;
    reg flush_ff;
    // Result path registers
    reg result_write_ff;
    reg [63:0] result_data_ff;
    reg [31:0] rdata_ff;
    // Next values
    reg [1:0] nxt_rounding_select;
    reg [4:0] nxt_flag;
    reg [4:0] nxt_enable;
    reg [5:0] nxt_cause;
    reg nxt_cc0;
    reg [6:0] nxt_cc_hi;
    reg nxt_flush;
    reg nxt_result_write;
    // Trap decision for a given cause and enable set
    function trap_of;
        input [5:0] cause;
        input [4:0] enable;
        begin
            trap_of = cause[5] | (|(cause[4:0] & enable));
        end
    endfunction
    // Assemble the control word
    function [31:0] pack_word;
        input [6:0] cc_hi;
        input fs;
        input cc0;
        input [5:0] cause;
        input [4:0] enable;
        input [4:0] flag;
        input [1:0] rnd;
        begin
            pack_word = {cc_hi, fs, cc0, 5'h00, cause, enable, flag, rnd};
        end
    endfunction
    // Trap from an operation that completes this cycle
    wire op_trap = OP_DONE & trap_of(OP_CAUSE, enable_ff);
    // Standing trap from the stored word
    wire held_trap = trap_of(cause_ff, enable_ff);
    // Pipeline idle means reads may answer
    wire pipe_idle = (OPS_IN_FLIGHT == {PIPE_DEPTH_W{1'b0}}) & ~OP_DONE;
    // Next-state of the control word
    always @* begin
        nxt_rounding_select = rounding_select_ff;
        nxt_flag = flag_ff;
        nxt_enable = enable_ff;
        nxt_cause = cause_ff;
        nxt_cc0 = cc0_ff;
        nxt_cc_hi = cc_hi_ff;
        nxt_flush = flush_ff;
        nxt_result_write = 1'b0;
        if (OP_DONE) begin
            nxt_cause = OP_CAUSE;
            if (op_trap) begin
                nxt_result_write = 1'b0;
            end else begin
                nxt_result_write = 1'b1;
                nxt_flag = flag_ff | OP_CAUSE[4:0];
                // Compare results update condition bits
                if (OP_COMPARE) begin
                    nxt_cc0 = OP_COND[0];
                    nxt_cc_hi = OP_COND[7:1];
                end
            end
        end else if (CTRL_WRITE) begin
            nxt_rounding_select = CTRL_WDATA[`RND_HI:`RND_LO];
            nxt_flag = CTRL_WDATA[`FLAG_HI:`FLAG_LO];
            nxt_enable = CTRL_WDATA[`ENA_HI:`ENA_LO];
            nxt_cause = CTRL_WDATA[`CAUSE_HI:`CAUSE_LO];
            nxt_cc0 = CTRL_WDATA[`CC0_BIT];
            nxt_cc_hi = CTRL_WDATA[`CC_HI_HI:`CC_HI_LO];
            nxt_flush = CTRL_WDATA[`FS_BIT];
        end
    end
    // Control word registers
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rounding_select_ff <= `ROUND_NEAREST_EVEN;
            flag_ff <= 5'h00;
            enable_ff <= 5'h00;
            cause_ff <= 6'h00;
            cc0_ff <= 1'b0;
            cc_hi_ff <= 7'h00;
            flush_ff <= 1'b0;
            result_write_ff <= 1'b0;
        end else begin
            rounding_select_ff <= nxt_rounding_select;
            flag_ff <= nxt_flag;
            enable_ff <= nxt_enable;
            cause_ff <= nxt_cause;
            cc0_ff <= nxt_cc0;
            cc_hi_ff <= nxt_cc_hi;
            flush_ff <= nxt_flush;
            result_write_ff <= nxt_result_write;
        end
    end
    // Result data register, loaded only for untrapped operations
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            result_data_ff <= 64'h0000000000000000;
        end else if (nxt_result_write) begin
            result_data_ff <= DEFAULT_RESULT;
        end
    end
    // Read data register, sampled from the control word every cycle
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rdata_ff <= `CTRL_RESET;
        end else begin
            rdata_ff <= pack_word(cc_hi_ff, flush_ff, cc0_ff, cause_ff, enable_ff,
                                  flag_ff, rounding_select_ff);
        end
    end
    // Read answer: held off while work is in flight or a trap stands
    // drain before read
    assign CTRL_READ_ACK = CTRL_READ_REQ & pipe_idle & ~held_trap & ~CTRL_WRITE;
    assign CTRL_RDATA = rdata_ff;
    // Exception output: immediate on a trapping op, held while word traps
    // immediate exception
    assign FP_EXCEPTION = op_trap | held_trap;
    assign RESULT_WRITE = result_write_ff;
    assign RESULT_DATA = result_data_ff;
    assign ROUNDING_SELECT = rounding_select_ff;
    assign FLUSH_DENORM = flush_ff;
    // Rounding increment decision for the datapath
    reg round_inc;
    always @* begin
        case (rounding_select_ff)
            `ROUND_NEAREST_EVEN: round_inc = ROUND_GUARD & (ROUND_STICKY | ROUND_LSB);
            `ROUND_TOWARD_ZERO: round_inc = 1'b0;
            `ROUND_TOWARD_PLUS_INF: round_inc = ~ROUND_SIGN & (ROUND_GUARD | ROUND_STICKY);
            `ROUND_TOWARD_MINUS_INF: round_inc = ROUND_SIGN & (ROUND_GUARD | ROUND_STICKY);
            default: round_inc = 1'b0;
        endcase
    end
    assign ROUND_INCREMENT = round_inc;
    // Operand classification
    // format decode
    fp_operand_classify u_classify (
        .OPERAND(CLASS_OPERAND),
        .IS_DOUBLE(CLASS_IS_DOUBLE),
        .IS_FIXED(CLASS_IS_FIXED),
        .FIXED_LONG(CLASS_FIXED_LONG),
        .CLASS_CODE(CLASS_CODE),
        .SIGN(CLASS_SIGN),
        .UNBIASED_EXP(CLASS_EXP)
    );
endmodule // fp_status_exception_logic
`default_nettype wire

// ---- verification/fp_status_exception_logic_assertions.sv ----
// Checker for the floating-point status and exception block
`timescale 1ns/1ps
`default_nettype none
module fp_status_checks #(
    parameter PIPE_DEPTH_W = 4
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Operation completion
    input wire logic OP_DONE,
    input wire logic [5:0] OP_CAUSE,
    input wire logic [PIPE_DEPTH_W-1:0] OPS_IN_FLIGHT,
    input wire logic [63:0] DEFAULT_RESULT,
    // Control moves
    input wire logic CTRL_WRITE,
    input wire logic [31:0] CTRL_WDATA,
    input wire logic CTRL_READ_ACK,
    input wire logic [31:0] CTRL_RDATA,
    // Results and control
    input wire logic RESULT_WRITE,
    input wire logic [63:0] RESULT_DATA,
    input wire logic FP_EXCEPTION,
    input wire logic [1:0] ROUNDING_SELECT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    // Accepted control write, untrapped and trapped operation
    sequence s_wr; CTRL_WRITE && !OP_DONE; endsequence
    sequence s_ok; OP_DONE && !FP_EXCEPTION; endsequence
    sequence s_trap; OP_DONE && FP_EXCEPTION; endsequence
    a_read_drain: assert property (
        CTRL_READ_ACK |-> OPS_IN_FLIGHT == 0 && !FP_EXCEPTION) else $error("early read");
    a_unimp_trap: assert property (
        OP_DONE && OP_CAUSE[5] |-> FP_EXCEPTION) else $error("unimp no trap");
    a_trap_no_result: assert property (
        s_trap |=> !RESULT_WRITE) else $error("trapped result stored");
    a_default_store: assert property (
        s_ok |=> RESULT_WRITE && RESULT_DATA == $past(DEFAULT_RESULT)) else $error("no result");
    a_cause_shown: assert property (
        OP_DONE |-> ##2 CTRL_RDATA[17:12] == $past(OP_CAUSE, 2)) else $error("cause wrong");
    a_write_trap: assert property (
        CTRL_WRITE && !OP_DONE && (CTRL_WDATA[17] || |(CTRL_WDATA[16:12] & CTRL_WDATA[11:7]))
        |=> FP_EXCEPTION || OP_DONE) else $error("write no trap");
    a_round_select: assert property (
        s_wr |=> ROUNDING_SELECT == $past(CTRL_WDATA[1:0])) else $error("rounding wrong");
    a_write_back: assert property (
        s_wr |-> ##2 CTRL_RDATA == ($past(CTRL_WDATA, 2) & 32'hFF83FFFF)) else $error("word");
    a_flag_set: assert property (
        s_ok |-> ##2 (CTRL_RDATA[6:2] & $past(OP_CAUSE[4:0], 2)) == $past(OP_CAUSE[4:0], 2))
        else $error("flag not set");
    a_flag_trap: assert property (
        s_trap |-> ##2 CTRL_RDATA[6:2] == $past(CTRL_RDATA[6:2])) else $error("flag moved");
endmodule // fp_status_checks
bind fp_status_exception_logic fp_status_checks #(.PIPE_DEPTH_W(PIPE_DEPTH_W)) i_checks (
    .CLK, .NRST, .OP_DONE, .OP_CAUSE, .OPS_IN_FLIGHT, .DEFAULT_RESULT, .CTRL_WRITE,
    .CTRL_WDATA, .CTRL_READ_ACK, .CTRL_RDATA, .RESULT_WRITE, .RESULT_DATA, .FP_EXCEPTION,
    .ROUNDING_SELECT);
`default_nettype wire

// ---- verification/fp_cpu_moves.sv ----
// Model of the integer pipeline issuing control word moves
`timescale 1ns/1ps
`default_nettype none
module fp_cpu_moves (
    // Clock
    input wire logic CLK,
    // Control word moves
    output logic CTRL_WRITE,
    output logic [31:0] CTRL_WDATA,
    output logic CTRL_READ_REQ,
    input wire logic CTRL_READ_ACK,
    input wire logic [31:0] CTRL_RDATA
);
    // Idle bus at time zero
    initial begin
        CTRL_WRITE = 1'b0;
        CTRL_WDATA = 32'h5A5A5A5A;
        CTRL_READ_REQ = 1'b0;
    end
    // idle-time writes: callers keep the pipeline empty
    task automatic wr(input logic [31:0] d);
        @(posedge CLK);
        #1 CTRL_WRITE = 1'b1;
        CTRL_WDATA = d;
        @(posedge CLK);
        #1 CTRL_WRITE = 1'b0;
        // Released data shows the inverse, never a stale copy
        CTRL_WDATA = ~d;
    endtask
    // Request held until the answer edge, at most 50 cycles
    task automatic rd(output logic [31:0] d, output bit to);
        to = 1'b1;
        d = 32'h0;
        @(posedge CLK);
        #1 CTRL_READ_REQ = 1'b1;
        // Answer taken at the rising edge where acknowledge is sampled high
        for (int i = 0; i < 50 && to; i++) begin
            @(posedge CLK);
            if (CTRL_READ_ACK === 1'b1) begin
                d = CTRL_RDATA;
                to = 1'b0;
            end
        end
        // Request dropped just after the answer edge
        #1 CTRL_READ_REQ = 1'b0;
    endtask
endmodule // fp_cpu_moves
`default_nettype wire

// ---- verification/tb_fp_status_exception_logic.sv ----
// Self-checking bench for the floating-point status and exception block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module tb_fp_status_exception_logic;
    logic CLK = 1'b0;
    logic NRST = 1'b0;
    logic OP_DONE = 1'b0;
    logic [5:0] OP_CAUSE = 6'h00;
    logic [3:0] OPS_IN_FLIGHT = 4'h0;
    logic [63:0] DEFAULT_RESULT = 64'h0;
    logic [63:0] CLASS_OPERAND = 64'h0;
    logic CLASS_IS_DOUBLE = 1'b0;
    logic CLASS_IS_FIXED = 1'b0;
    logic CLASS_FIXED_LONG = 1'b0;
    logic OP_COMPARE = 1'b0;
    logic [7:0] OP_COND = 8'h00;
    logic ROUND_SIGN = 1'b0;
    wire logic FLUSH_DENORM;
    logic ROUND_LSB = 1'b0;
    logic ROUND_GUARD = 1'b0;
    logic ROUND_STICKY = 1'b0;
    wire logic CTRL_WRITE, CTRL_READ_REQ, CTRL_READ_ACK, RESULT_WRITE, FP_EXCEPTION;
    wire logic ROUND_INCREMENT, CLASS_SIGN;
    wire logic [31:0] CTRL_WDATA, CTRL_RDATA;
    wire logic [63:0] RESULT_DATA;
    wire logic [1:0] ROUNDING_SELECT;
    wire logic [2:0] CLASS_CODE;
    wire logic signed [12:0] CLASS_EXP;
    int failures = 0;
    int n_tests = 0;
    logic [31:0] v;
    bit to;
    // 100 ns clock
    always #50 CLK = ~CLK;
    fp_status_exception_logic #(.PIPE_DEPTH_W(4)) i_dut (.CLK, .NRST, .OP_DONE, .OP_CAUSE,
        .OP_COMPARE, .OP_COND, .OPS_IN_FLIGHT, .CTRL_WRITE, .CTRL_WDATA,
        .CTRL_READ_REQ, .CTRL_READ_ACK, .CTRL_RDATA, .DEFAULT_RESULT, .RESULT_WRITE,
        .RESULT_DATA, .FP_EXCEPTION, .ROUNDING_SELECT, .FLUSH_DENORM, .CLASS_OPERAND,
        .CLASS_IS_DOUBLE, .CLASS_IS_FIXED, .CLASS_FIXED_LONG, .CLASS_CODE, .CLASS_SIGN,
        .CLASS_EXP, .ROUND_SIGN, .ROUND_LSB, .ROUND_GUARD, .ROUND_STICKY, .ROUND_INCREMENT);
    fp_cpu_moves i_cpu (.CLK, .CTRL_WRITE, .CTRL_WDATA, .CTRL_READ_REQ, .CTRL_READ_ACK,
        .CTRL_RDATA);
    // Counts, verdict and end of run
    task automatic results();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Read the control word and compare; a hang ends the run
    task automatic rdc(input logic [31:0] e);
        i_cpu.rd(v, to);
        if (to) begin
            failures++;
            results();
        end
        `CHK(v, e)
    endtask
    // One completing operation, checked for trap or stored result
    task automatic op(input logic [5:0] c, input logic trap);
        @(posedge CLK);
        #1 OP_DONE = 1'b1;
        OP_CAUSE = c;
        DEFAULT_RESULT = {26'h0, c, 32'hC0DE0000};
        @(posedge CLK);
        #1 OP_DONE = 1'b0;
        `CHK(FP_EXCEPTION, trap)
        `CHK(RESULT_WRITE, ~trap)
        if (!trap) `CHK(RESULT_DATA, {26'h0, c, 32'hC0DE0000})
    endtask
    // Classify one operand
    task automatic cls(input logic d, input logic [63:0] x, input logic [2:0] e);
        CLASS_IS_DOUBLE = d;
        CLASS_OPERAND = x;
        #1 `CHK(CLASS_CODE, e)
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge CLK);
        #1 NRST = 1'b1;
        rdc(32'h0);
        for (int m = 0; m < 4; m++) begin
            i_cpu.wr(32'(m));
            `CHK(ROUNDING_SELECT, 2'(m))
        end
        i_cpu.wr(32'hFFFC0F7F);
        rdc(32'hFF800F7F);
        i_cpu.wr(32'h00000F00);
        ROUND_GUARD = 1'b1;
        for (int i = 0; i < 4; i++) begin
            {ROUND_LSB, ROUND_STICKY} = 2'(i);
            #1 `CHK(ROUND_INCREMENT, ROUND_LSB | ROUND_STICKY)
        end
        $display("done: control word");
        op(6'h01, 1'b0);
        rdc(32'h00001F04);
        op(6'h0A, 1'b1);
        @(posedge CLK);
        #1 `CHK(CTRL_RDATA, 32'h0000AF04)
        i_cpu.wr(32'h00000F04);
        `CHK(FP_EXCEPTION, 1'b0)
        op(6'h20, 1'b1);
        i_cpu.wr(32'h00000F04);
        i_cpu.wr(32'h00001080);
        `CHK(FP_EXCEPTION, 1'b1)
        i_cpu.wr(32'h0);
        $display("done: exceptions");
        OPS_IN_FLIGHT = 4'h2;
        fork
            rdc(32'h0);
            begin
                repeat (4) @(posedge CLK);
                #1 OPS_IN_FLIGHT = 4'h0;
            end
        join
        $display("done: drain");
        // Compare result lands in the condition bits
        OP_COMPARE = 1'b1;
        OP_COND = 8'hA5;
        op(6'h00, 1'b0);
        OP_COMPARE = 1'b0;
        rdc(32'hA4800000);
        // Flush bit and directed rounding by sign
        i_cpu.wr(32'h01000003);
        `CHK(FLUSH_DENORM, 1'b1)
        ROUND_SIGN = 1'b1;
        #1 `CHK(ROUND_INCREMENT, 1'b1)
        ROUND_SIGN = 1'b0;
        #1 `CHK(ROUND_INCREMENT, 1'b0)
        i_cpu.wr(32'h0);
        $display("done: compare and modes");
        cls(1'b0, 64'h0, 3'h0);
        cls(1'b0, 64'h1, 3'h1);
        cls(1'b0, 64'h3F800000, 3'h2);
        `CHK(CLASS_EXP, 13'h0000)
        cls(1'b0, 64'h7F800000, 3'h3);
        cls(1'b0, 64'h7FC00000, 3'h4);
        cls(1'b0, 64'h7F800001, 3'h5);
        cls(1'b1, 64'h7FF8000000000000, 3'h4);
        cls(1'b1, 64'h3FF0000000000000, 3'h2);
        `CHK(CLASS_EXP, 13'h0000)
        cls(1'b1, 64'h8000000000000000, 3'h0);
        `CHK(CLASS_SIGN, 1'b1)
        CLASS_IS_FIXED = 1'b1;
        cls(1'b0, 64'hFFFFFFFF, 3'h2);
        `CHK(CLASS_SIGN, 1'b1)
        CLASS_FIXED_LONG = 1'b1;
        cls(1'b0, 64'h8000000000000000, 3'h2);
        `CHK(CLASS_SIGN, 1'b1)
        cls(1'b0, 64'h0000000100000000, 3'h2);
        `CHK(CLASS_SIGN, 1'b0)
        $display("done: classify");
        results();
    end
endmodule // tb_fp_status_exception_logic
`default_nettype wire
